// ### logic/global_irq_summary_and_connection_ctrl.v
// Contract
// - serial tx summary flag bit 4 of 0x07 follows enabled serial tx events.
// - serial rx summary flag bit 0 of 0x07 follows enabled serial rx events.
// - ethernet enable bit 0 of 0x08 gates ethernet summary onto interrupt.
// - ethernet summary flag bit 0 of 0x09 follows enabled ethernet events.
// - tx queue enable bit 4 of 0x0A gates tx queue summary onto interrupt.
// - rx queue enable bit 0 of 0x0A gates rx queue summary onto interrupt.
// - tx queue flag bit 4 of 0x0B follows threshold or overflow events.
// - rx queue flag bit 0 of 0x0B follows threshold or overflow events.
// - inverse mux enable bit 1 of 0x0C gates its summary onto interrupt.
// - bit tester enable bit 0 of 0x0C gates its summary onto interrupt.
// - inverse mux flag bit 1 of 0x0D follows its pending enabled event.
// - bit tester flag bit 0 of 0x0D follows its pending enabled event.
// - connect select bit 0 resets to 1 and joins ethernet and serial.
// - writing zero to the connection register breaks the connection.
// - disconnected: ones to serial tx and hdlc rx, hdlc clocks gated.
// - bit 3 of 0x12 high holds the rx queue read pointer in reset.
// - bit 2 of 0x12 high holds the rx queue write pointer in reset.
// - bit 1 of 0x12 high holds the tx queue read pointer in reset.
// - bit 0 of 0x12 high holds the tx queue write pointer in reset.
// - interrupt output is driven low while active.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "global_irq_map.vh"
module global_irq_summary_and_connection_ctrl (
   // clock and reset
   input  wire        core_clk_i,
   input  wire        rstn_i,
   // axi4-lite write address
   input  wire [7:0]  s_axi_awaddr_i,
   input  wire        s_axi_awvalid_i,
   output reg         s_axi_awready_o,
   // axi4-lite write data
   input  wire [31:0] s_axi_wdata_i,
   input  wire [3:0]  s_axi_wstrb_i,
   input  wire        s_axi_wvalid_i,
   output reg         s_axi_wready_o,
   // axi4-lite write response
   output reg  [1:0]  s_axi_bresp_o,
   output reg         s_axi_bvalid_o,
   input  wire        s_axi_bready_i,
   // axi4-lite read address
   input  wire [7:0]  s_axi_araddr_i,
   input  wire        s_axi_arvalid_i,
   output reg         s_axi_arready_o,
   // axi4-lite read data
   output reg  [31:0] s_axi_rdata_o,
   output reg  [1:0]  s_axi_rresp_o,
   output reg         s_axi_rvalid_o,
   input  wire        s_axi_rready_i,
   // unit event levels (already enabled inside each unit)
   input  wire        serial_tx_event_i,
   input  wire        serial_rx_event_i,
   input  wire        ethernet_summary_source_i,
   input  wire        tx_queue_event_i,
   input  wire        rx_queue_event_i,
   input  wire        inverse_mux_event_i,
   input  wire        bit_tester_event_i,
   // interrupt pin, active low
   output reg         irq_n_o,
   // connection control
   output reg         port_connect_select_o,
   output reg         serial_tx_force_ones_o,
   output reg         hdlc_rx_force_ones_o,
   output reg         hdlc_tx_clk_en_o,
   output reg         hdlc_rx_clk_en_o,
   // queue pointer resets, level
   output reg         rx_queue_read_ptr_reset_o,
   output reg         rx_queue_write_ptr_reset_o,
   output reg         tx_queue_read_ptr_reset_o,
   output reg         tx_queue_write_ptr_reset_o
);

   // summary flags
   reg        serial_tx_summary_flag;
   reg        serial_rx_summary_flag;
   reg        ethernet_summary_flag;
   reg        tx_queue_summary_flag;
   reg        rx_queue_summary_flag;
   reg        inverse_mux_summary_flag;
   reg        bit_tester_summary_flag;
   // writable registers
   reg        ethernet_summary_enable;
   reg        tx_queue_summary_enable;
   reg        rx_queue_summary_enable;
   reg        inverse_mux_summary_enable;
   reg        bit_tester_summary_enable;
   reg        port_connect_select;
   reg [3:0]  queue_pointer_reset;
   // write channel capture
   reg        aw_held;
   reg        w_held;
   reg [7:0]  aw_addr;
   reg [31:0] w_data;
   reg [3:0]  w_strb;
   wire       do_write;
   wire       wr_hit;
   wire [7:0] wr_byte;
   reg [7:0]  rd_byte;
   reg        rd_hit;
   wire       next_irq;

   // reset images of the writable registers; each field takes its bit from here
   localparam [7:0] rst_enable_byte  = `RST_IRQ_ENABLE;
   localparam [7:0] rst_connect_byte = `RST_PORT_CONNECTION;
   localparam [7:0] rst_pointer_byte = `RST_QUEUE_POINTER;

   // byte address to register index; misaligned addresses map nowhere
   function [8:0] to_index;
      input [7:0] addr;
      begin
         to_index = {(addr[1:0] != 2'b00), 2'b00, addr[7:2]};
      end
   endfunction

   // known-register test used by both read and write decode
   function is_mapped;
      input [8:0] idx;
      begin
         case (idx)
            {1'b0, `IDX_SERIAL_IRQ_SUMMARY},
            {1'b0, `IDX_ETHERNET_IRQ_ENABLE},
            {1'b0, `IDX_ETHERNET_IRQ_SUMMARY},
            {1'b0, `IDX_QUEUE_IRQ_ENABLE},
            {1'b0, `IDX_QUEUE_IRQ_SUMMARY},
            {1'b0, `IDX_MUX_TESTER_IRQ_EN},
            {1'b0, `IDX_MUX_TESTER_IRQ_SUM},
            {1'b0, `IDX_PORT_CONNECTION_SEL},
            {1'b0, `IDX_QUEUE_POINTER_RESET}: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
         endcase
      end
   endfunction

   // place two one-bit fields of a register at their bit positions; the
   // second field is written last, so the two positions must differ
   function [7:0] pack_pair;
      input         hi_val;
      input integer hi_pos;
      input         lo_val;
      input integer lo_pos;
      begin
         pack_pair         = 8'h00;
         pack_pair[hi_pos] = hi_val;
         pack_pair[lo_pos] = lo_val;
      end
   endfunction

   // flags follow unit state each cycle, no software path at all
   // a unit that lowers its event line clears the flag on the next edge, so
   // there is no set/clear race; software sees the level, not a history
   always @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         serial_tx_summary_flag   <= 1'b0;
         serial_rx_summary_flag   <= 1'b0;
         ethernet_summary_flag    <= 1'b0;
         tx_queue_summary_flag    <= 1'b0;
         rx_queue_summary_flag    <= 1'b0;
         inverse_mux_summary_flag <= 1'b0;
         bit_tester_summary_flag  <= 1'b0;
      end
      else
      begin
         serial_tx_summary_flag   <= serial_tx_event_i;
         serial_rx_summary_flag   <= serial_rx_event_i;
         ethernet_summary_flag    <= ethernet_summary_source_i;
         tx_queue_summary_flag    <= tx_queue_event_i;
         rx_queue_summary_flag    <= rx_queue_event_i;
         inverse_mux_summary_flag <= inverse_mux_event_i;
         bit_tester_summary_flag  <= bit_tester_event_i;
      end
   end

   // serial flags have their enable upstream, so they drive the pin directly
   // limitation: serial sources cannot be masked here, only at their unit
   assign next_irq = serial_tx_summary_flag | serial_rx_summary_flag
                   | (ethernet_summary_flag & ethernet_summary_enable)
                   | (tx_queue_summary_flag & tx_queue_summary_enable)
                   | (rx_queue_summary_flag & rx_queue_summary_enable)
                   | (inverse_mux_summary_flag & inverse_mux_summary_enable)
                   | (bit_tester_summary_flag & bit_tester_summary_enable);

   // write happens once both address and data are held and no response pends
   // holding both channels until the response is taken keeps one write in
   // flight, so a fresh address can never pair with stale data
   assign do_write = aw_held & w_held & ~s_axi_bvalid_o;
   assign wr_hit   = is_mapped(to_index(aw_addr));
   assign wr_byte  = w_data[7:0];

   // axi write channels: accept each independently, answer after both
   always @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         aw_held         <= 1'b0;
         w_held          <= 1'b0;
         aw_addr         <= 8'h00;
         w_data          <= 32'h0000_0000;
         w_strb          <= 4'h0;
         s_axi_awready_o <= 1'b1;
         s_axi_wready_o  <= 1'b1;
         s_axi_bvalid_o  <= 1'b0;
         s_axi_bresp_o   <= `RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid_i && s_axi_awready_o)
         begin
            aw_held         <= 1'b1;
            aw_addr         <= s_axi_awaddr_i;
            s_axi_awready_o <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o)
         begin
            w_held         <= 1'b1;
            w_data         <= s_axi_wdata_i;
            w_strb         <= s_axi_wstrb_i;
            s_axi_wready_o <= 1'b0;
         end
         if (do_write)
         begin
            aw_held        <= 1'b0;
            w_held         <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
         // ready returns only after the response is taken
         if (s_axi_bvalid_o && s_axi_bready_i)
         begin
            s_axi_bvalid_o  <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
         end
      end
   end

   // register stores; writes to summary addresses fall through unchanged
   // a write without byte lane 0 is answered but leaves every register as it was
   always @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         ethernet_summary_enable    <= rst_enable_byte[`BIT_ETHERNET];
         tx_queue_summary_enable    <= rst_enable_byte[`BIT_TX_QUEUE];
         rx_queue_summary_enable    <= rst_enable_byte[`BIT_RX_QUEUE];
         inverse_mux_summary_enable <= rst_enable_byte[`BIT_INVERSE_MUX];
         bit_tester_summary_enable  <= rst_enable_byte[`BIT_BIT_TESTER];
         port_connect_select        <= rst_connect_byte[`BIT_CONNECT];
         queue_pointer_reset        <= rst_pointer_byte[3:0];
      end
      else if (do_write && w_strb[0])
      begin
         case (to_index(aw_addr))
            {1'b0, `IDX_ETHERNET_IRQ_ENABLE}:
               ethernet_summary_enable <= wr_byte[`BIT_ETHERNET];
            {1'b0, `IDX_QUEUE_IRQ_ENABLE}:
            begin
               tx_queue_summary_enable <= wr_byte[`BIT_TX_QUEUE];
               rx_queue_summary_enable <= wr_byte[`BIT_RX_QUEUE];
            end
            {1'b0, `IDX_MUX_TESTER_IRQ_EN}:
            begin
               inverse_mux_summary_enable <= wr_byte[`BIT_INVERSE_MUX];
               bit_tester_summary_enable  <= wr_byte[`BIT_BIT_TESTER];
            end
            {1'b0, `IDX_PORT_CONNECTION_SEL}:
               port_connect_select <= wr_byte[`BIT_CONNECT];
            {1'b0, `IDX_QUEUE_POINTER_RESET}:
               queue_pointer_reset <= wr_byte[3:0];
            default:
               queue_pointer_reset <= queue_pointer_reset;
         endcase
      end
   end

   // read data mux
   always @*
   begin
      rd_byte = 8'h00;
      rd_hit  = is_mapped(to_index(s_axi_araddr_i));
      case (to_index(s_axi_araddr_i))
         {1'b0, `IDX_SERIAL_IRQ_SUMMARY}:
            rd_byte = pack_pair(serial_tx_summary_flag, `BIT_SERIAL_TX,
                                serial_rx_summary_flag, `BIT_SERIAL_RX);
         {1'b0, `IDX_ETHERNET_IRQ_ENABLE}:
            rd_byte = {7'b000_0000, ethernet_summary_enable};
         {1'b0, `IDX_ETHERNET_IRQ_SUMMARY}:
            rd_byte = {7'b000_0000, ethernet_summary_flag};
         {1'b0, `IDX_QUEUE_IRQ_ENABLE}:
            rd_byte = pack_pair(tx_queue_summary_enable, `BIT_TX_QUEUE,
                                rx_queue_summary_enable, `BIT_RX_QUEUE);
         {1'b0, `IDX_QUEUE_IRQ_SUMMARY}:
            rd_byte = pack_pair(tx_queue_summary_flag, `BIT_TX_QUEUE,
                                rx_queue_summary_flag, `BIT_RX_QUEUE);
         {1'b0, `IDX_MUX_TESTER_IRQ_EN}:
            rd_byte = pack_pair(inverse_mux_summary_enable, `BIT_INVERSE_MUX,
                                bit_tester_summary_enable, `BIT_BIT_TESTER);
         {1'b0, `IDX_MUX_TESTER_IRQ_SUM}:
            rd_byte = pack_pair(inverse_mux_summary_flag, `BIT_INVERSE_MUX,
                                bit_tester_summary_flag, `BIT_BIT_TESTER);
         {1'b0, `IDX_PORT_CONNECTION_SEL}:
            rd_byte = {7'b000_0000, port_connect_select};
         {1'b0, `IDX_QUEUE_POINTER_RESET}:
            rd_byte = {4'h0, queue_pointer_reset};
         default:
            rd_byte = 8'h00;
      endcase
   end

   // axi read: one outstanding, arready drops until rdata is taken
   // rdata is captured once, so a late rready still sees the value of the request
   always @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h0000_0000;
         s_axi_rresp_o   <= `RESP_OKAY;
      end
      else if (s_axi_arvalid_i && s_axi_arready_o)
      begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o  <= 1'b1;
         s_axi_rdata_o   <= {24'h00_0000, rd_byte};
         s_axi_rresp_o   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rvalid_o && s_axi_rready_i)
      begin
         s_axi_rvalid_o  <= 1'b0;
         s_axi_arready_o <= 1'b1;
      end
   end

   // outputs registered; force-ones and clock gating track the connect bit
   // the pin idles high out of reset, so no false interrupt follows release
   always @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         irq_n_o                    <= 1'b1;
         port_connect_select_o      <= rst_connect_byte[`BIT_CONNECT];
         serial_tx_force_ones_o     <= ~rst_connect_byte[`BIT_CONNECT];
         hdlc_rx_force_ones_o       <= ~rst_connect_byte[`BIT_CONNECT];
         hdlc_tx_clk_en_o           <= rst_connect_byte[`BIT_CONNECT];
         hdlc_rx_clk_en_o           <= rst_connect_byte[`BIT_CONNECT];
         rx_queue_read_ptr_reset_o  <= rst_pointer_byte[`BIT_RXQ_RD_PTR];
         rx_queue_write_ptr_reset_o <= rst_pointer_byte[`BIT_RXQ_WR_PTR];
         tx_queue_read_ptr_reset_o  <= rst_pointer_byte[`BIT_TXQ_RD_PTR];
         tx_queue_write_ptr_reset_o <= rst_pointer_byte[`BIT_TXQ_WR_PTR];
      end
      else
      begin
         irq_n_o                    <= ~next_irq;
         port_connect_select_o      <= port_connect_select;
         serial_tx_force_ones_o     <= ~port_connect_select;
         hdlc_rx_force_ones_o       <= ~port_connect_select;
         hdlc_tx_clk_en_o           <= port_connect_select;
         hdlc_rx_clk_en_o           <= port_connect_select;
         rx_queue_read_ptr_reset_o  <= queue_pointer_reset[`BIT_RXQ_RD_PTR];
         rx_queue_write_ptr_reset_o <= queue_pointer_reset[`BIT_RXQ_WR_PTR];
         tx_queue_read_ptr_reset_o  <= queue_pointer_reset[`BIT_TXQ_RD_PTR];
         tx_queue_write_ptr_reset_o <= queue_pointer_reset[`BIT_TXQ_WR_PTR];
      end
   end

endmodule // global_irq_summary_and_connection_ctrl
`default_nettype wire

// ### logic/global_irq_map.vh
`ifndef GLOBAL_IRQ_MAP_VH
`define GLOBAL_IRQ_MAP_VH
// register indices (printed offsets are not all multiples of four)
`define IDX_SERIAL_IRQ_SUMMARY   8'h07
`define IDX_ETHERNET_IRQ_ENABLE  8'h08
`define IDX_ETHERNET_IRQ_SUMMARY 8'h09
`define IDX_QUEUE_IRQ_ENABLE     8'h0A
`define IDX_QUEUE_IRQ_SUMMARY    8'h0B
`define IDX_MUX_TESTER_IRQ_EN    8'h0C
`define IDX_MUX_TESTER_IRQ_SUM   8'h0D
`define IDX_PORT_CONNECTION_SEL  8'h0E
`define IDX_QUEUE_POINTER_RESET  8'h12
// field positions
`define BIT_SERIAL_TX            4
`define BIT_SERIAL_RX            0
`define BIT_ETHERNET             0
`define BIT_TX_QUEUE             4
`define BIT_RX_QUEUE             0
`define BIT_INVERSE_MUX          1
`define BIT_BIT_TESTER           0
`define BIT_CONNECT              0
`define BIT_RXQ_RD_PTR           3
`define BIT_RXQ_WR_PTR           2
`define BIT_TXQ_RD_PTR           1
`define BIT_TXQ_WR_PTR           0
// reset values
`define RST_IRQ_ENABLE           8'h00
`define RST_PORT_CONNECTION      8'h01
`define RST_QUEUE_POINTER        8'h00
// axi responses
`define RESP_OKAY                2'b00
`define RESP_SLVERR              2'b10
`endif

// ### test/global_irq_summary_and_connection_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module global_irq_summary_and_connection_ctrl_checker (
   // clock and reset
   input wire logic        core_clk_i,
   input wire logic        rstn_i,
   // register bus
   input wire logic        s_axi_awvalid_i,
   input wire logic        s_axi_awready_o,
   input wire logic        s_axi_wvalid_i,
   input wire logic        s_axi_wready_o,
   input wire logic [1:0]  s_axi_bresp_o,
   input wire logic        s_axi_bvalid_o,
   input wire logic        s_axi_bready_i,
   input wire logic        s_axi_arvalid_i,
   input wire logic        s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic        s_axi_rvalid_o,
   input wire logic        s_axi_rready_i,
   // unit events and block outputs
   input wire logic        serial_tx_event_i,
   input wire logic        serial_rx_event_i,
   input wire logic        ethernet_summary_source_i,
   input wire logic        tx_queue_event_i,
   input wire logic        rx_queue_event_i,
   input wire logic        inverse_mux_event_i,
   input wire logic        bit_tester_event_i,
   input wire logic        irq_n_o,
   input wire logic        port_connect_select_o,
   input wire logic        serial_tx_force_ones_o,
   input wire logic        hdlc_rx_force_ones_o,
   input wire logic        hdlc_tx_clk_en_o,
   input wire logic        hdlc_rx_clk_en_o
);
   default clocking dcb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   // with no unit event at all nothing may hold the pin low
   wire any_event = serial_tx_event_i | serial_rx_event_i | ethernet_summary_source_i |
                    tx_queue_event_i | rx_queue_event_i | inverse_mux_event_i |
                    bit_tester_event_i;
   // serial flags carry no local enable, so they reach the pin two edges on
   AST_SERIAL_TX_IRQ: assert property (serial_tx_event_i |-> ##2 !irq_n_o)
      else $error("serial tx event did not pull the interrupt low");
   AST_SERIAL_RX_IRQ: assert property (serial_rx_event_i |-> ##2 !irq_n_o)
      else $error("serial rx event did not pull the interrupt low");
   AST_IRQ_RELEASE: assert property (!any_event |-> ##2 irq_n_o)
      else $error("interrupt low with no event pending");
   AST_FORCE_ONES: assert property (serial_tx_force_ones_o == !port_connect_select_o &&
      hdlc_rx_force_ones_o == !port_connect_select_o)
      else $error("all-ones forcing disagrees with connection state");
   AST_CLK_GATE: assert property (hdlc_tx_clk_en_o == port_connect_select_o &&
      hdlc_rx_clk_en_o == port_connect_select_o)
      else $error("hdlc clock enables disagree with connection state");
   // bus timing as handed over: write answered two edges after capture
   AST_WRITE_ANSWER: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
      s_axi_wready_o |-> ##2 s_axi_bvalid_o)
      else $error("write response late");
   AST_AW_BUSY: assert property (s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o)
      else $error("write address still ready after capture");
   AST_READ_ANSWER: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read data late");
   AST_READ_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
      s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data dropped before ready");
   AST_WRITE_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
      s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response dropped before ready");
   AST_RDATA_UPPER: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h00_0000)
      else $error("read data upper bits not zero");
endmodule // global_irq_summary_and_connection_ctrl_checker
bind global_irq_summary_and_connection_ctrl global_irq_summary_and_connection_ctrl_checker
   checker_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .s_axi_awvalid_i(s_axi_awvalid_i),
   .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
   .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
   .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
   .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
   .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o),
   .s_axi_rready_i(s_axi_rready_i), .serial_tx_event_i(serial_tx_event_i),
   .serial_rx_event_i(serial_rx_event_i), .ethernet_summary_source_i(ethernet_summary_source_i),
   .tx_queue_event_i(tx_queue_event_i), .rx_queue_event_i(rx_queue_event_i),
   .inverse_mux_event_i(inverse_mux_event_i), .bit_tester_event_i(bit_tester_event_i),
   .irq_n_o(irq_n_o), .port_connect_select_o(port_connect_select_o),
   .serial_tx_force_ones_o(serial_tx_force_ones_o), .hdlc_rx_force_ones_o(hdlc_rx_force_ones_o),
   .hdlc_tx_clk_en_o(hdlc_tx_clk_en_o), .hdlc_rx_clk_en_o(hdlc_rx_clk_en_o));
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "global_irq_map.vh"
module tb;
   // bench-driven inputs
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0]  wstrb = 4'hF;
   logic [6:0]  ev = 7'h00;
   // design outputs
   wire         awready, wready, bvalid, arready, rvalid, irq_n, conn, tx_ones, rx_ones;
   wire         tx_clk_en, rx_clk_en;
   wire [1:0]   bresp, rresp;
   wire [31:0]  rdata;
   wire [3:0]   ptr_rst;
   // rdy_wait: cycles before bready/rready rise, so held responses are exercised
   int          fail_count = 0, samples_checked = 0, i, rdy_wait = 0;
   // summary place, flag bit and enable place (zero when none) for each event
   logic [7:0]  s_addr [7] = '{8'h1C, 8'h1C, 8'h24, 8'h2C, 8'h2C, 8'h34, 8'h34};
   logic [7:0]  e_addr [7] = '{8'h00, 8'h00, 8'h20, 8'h28, 8'h28, 8'h30, 8'h30};
   int          s_bit [7] = '{4, 0, 0, 4, 0, 1, 0};
   logic [7:0]  r_addr [9] = '{8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h48};
   always #4 clk = ~clk;
   global_irq_summary_and_connection_ctrl global_irq_summary_and_connection_ctrl_inst (
      .core_clk_i(clk), .rstn_i(rstn), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
      .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
      .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .serial_tx_event_i(ev[0]), .serial_rx_event_i(ev[1]), .ethernet_summary_source_i(ev[2]),
      .tx_queue_event_i(ev[3]), .rx_queue_event_i(ev[4]), .inverse_mux_event_i(ev[5]),
      .bit_tester_event_i(ev[6]), .irq_n_o(irq_n), .port_connect_select_o(conn),
      .serial_tx_force_ones_o(tx_ones), .hdlc_rx_force_ones_o(rx_ones),
      .hdlc_tx_clk_en_o(tx_clk_en), .hdlc_rx_clk_en_o(rx_clk_en),
      .rx_queue_read_ptr_reset_o(ptr_rst[3]), .rx_queue_write_ptr_reset_o(ptr_rst[2]),
      .tx_queue_read_ptr_reset_o(ptr_rst[1]), .tx_queue_write_ptr_reset_o(ptr_rst[0]));
   task test_done;
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED t=%0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // address and data offered together, each dropped once taken; bready up after
   // rdy_wait cycles and held until bvalid is seen with it
   task axi_write(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= (rdy_wait == 0);
      do
      begin
         @(posedge clk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (n >= rdy_wait && !bready) bready <= 1'b1;
      end while (!(bvalid && bready && !awvalid && !wvalid) && n < 200);
      bready <= 1'b0;
      if (n >= 200) chk(8'h00, 8'h01, "write hang");
      chk({6'h00, bresp}, {6'h00, er}, "write response");
   endtask
   task axi_read(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= (rdy_wait == 0);
      do
      begin
         @(posedge clk);
         n++;
         if (arready) arvalid <= 1'b0;
         if (n >= rdy_wait && !rready) rready <= 1'b1;
      end while (!(rvalid && rready && !arvalid) && n < 200);
      rready <= 1'b0;
      if (n >= 200) chk(8'h00, 8'h01, "read hang");
      chk(rdata[7:0], ed, "read data");
      chk({6'h00, rresp}, {6'h00, er}, "read response");
   endtask
   task wait_clk(input int k);
      repeat (k) @(posedge clk);
   endtask
   // unmapped, misaligned and read-only accesses, then every reset value
   task t_access_and_reset;
      axi_read(8'h00, 8'h00, `RESP_SLVERR);
      axi_write(8'h3C, 8'hFF, `RESP_SLVERR);
      axi_read(8'h21, 8'h00, `RESP_SLVERR);
      axi_write(8'h1C, 8'hFF, `RESP_OKAY);
      // a write without byte lane 0 must leave the connect bit set
      wstrb <= 4'h0;
      axi_write(8'h38, 8'h00, `RESP_OKAY);
      wstrb <= 4'hF;
      for (i = 0; i < 9; i++)
         axi_read(r_addr[i], (i == 7) ? 8'h01 : 8'h00, `RESP_OKAY);
      chk({7'h00, irq_n}, 8'h01, "interrupt idle level");
   endtask
   // each event sets its own flag; masked sources keep the pin high until enabled
   task t_flags_and_enables;
      for (i = 0; i < 7; i++)
      begin
         @(posedge clk);
         ev <= 7'h01 << i;
         wait_clk(4);
         axi_read(s_addr[i], 8'h01 << s_bit[i], `RESP_OKAY);
         chk({7'h00, irq_n}, (e_addr[i] == 8'h00) ? 8'h00 : 8'h01, "masked interrupt");
         if (e_addr[i] != 8'h00)
         begin
            axi_write(e_addr[i], 8'h01 << s_bit[i], `RESP_OKAY);
            wait_clk(4);
            chk({7'h00, irq_n}, 8'h00, "enabled interrupt");
            axi_write(e_addr[i], 8'h00, `RESP_OKAY);
         end
         @(posedge clk);
         ev <= 7'h00;
         wait_clk(4);
         chk({7'h00, irq_n}, 8'h01, "interrupt released");
         axi_read(s_addr[i], 8'h00, `RESP_OKAY);
      end
   endtask
   // break the connection, cycle each pointer reset, then reconnect
   task t_connection;
      rdy_wait = 3;
      axi_write(8'h38, 8'h00, `RESP_OKAY);
      wait_clk(2);
      chk({3'h0, conn, tx_ones, rx_ones, tx_clk_en, rx_clk_en}, 8'h0C, "disconnected");
      for (i = 0; i < 4; i++)
      begin
         axi_write(8'h48, 8'h01 << i, `RESP_OKAY);
         wait_clk(6);
         chk({4'h0, ptr_rst}, 8'h01 << i, "pointer reset held");
         axi_read(8'h48, 8'h01 << i, `RESP_OKAY);
         axi_write(8'h48, 8'h00, `RESP_OKAY);
         wait_clk(2);
         chk({4'h0, ptr_rst}, 8'h00, "pointer reset cleared");
      end
      axi_write(8'h38, 8'h01, `RESP_OKAY);
      wait_clk(2);
      chk({3'h0, conn, tx_ones, rx_ones, tx_clk_en, rx_clk_en}, 8'h13, "reconnected");
   endtask
   // watchdog well past the expected run of a few hundred cycles
   initial
   begin
      #400000;
      fail_count++;
      test_done();
   end
   initial
   begin
      wait_clk(16);
      rstn <= 1'b1;
      t_access_and_reset();
      t_flags_and_enables();
      t_connection();
      test_done();
   end
endmodule // tb
`default_nettype wire
